// ---- test/bpa_agu_props.sv ----
/* Port assertions for bpa_agu, bound into every instance.
   Assumes one clock and an active-low asynchronous reset. */
`timescale 1ns/100ps
module bpa_agu_props
  import bpa_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // watched ports
  input wire bpa_xwr_req_s xwr_req,
  input wire bpa_xwr_rsp_s xwr_rsp,
  input wire logic xwr_modulo_allow,
  input wire bpa_pacc_req_s pacc_req,
  input wire bpa_pacc_rsp_s pacc_rsp,
  input wire logic pacc_refused
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  property p_xrsp; xwr_rsp.valid == $past(xwr_req.valid); endproperty
  a_xrsp: assert property (p_xrsp) else $error("x answer late");
  property p_rmode; xwr_rsp.reversed |-> !$past(xwr_req.byte_op) &&
    $past(xwr_req.mode) inside {BPA_AM_PRE_INC, BPA_AM_POST_INC} &&
    $past(xwr_req.ptr_sel) != PTR_SEL_NONE; endproperty
  a_rmode: assert property (p_rmode) else $error("bad reversal");
  property p_rlsb; xwr_rsp.reversed |-> !xwr_rsp.ea[0] &&
    !xwr_rsp.wb_val[0]; endproperty
  a_rlsb: assert property (p_rlsb) else $error("odd reversed ea");
  property p_rwb; xwr_rsp.reversed |-> xwr_rsp.wb_en &&
    xwr_rsp.wb_sel == $past(xwr_req.ptr_sel); endproperty
  a_rwb: assert property (p_rwb) else $error("no writeback");
  property p_rpost; xwr_rsp.reversed && $past(xwr_req.mode) ==
    BPA_AM_POST_INC |-> xwr_rsp.ea == {$past(xwr_req.ptr_val[15:1]), 1'b0};
  endproperty
  a_rpost: assert property (p_rpost) else $error("post ea wrong");
  property p_mod; xwr_req.valid && xwr_modulo_allow |=> !xwr_rsp.reversed;
  endproperty
  a_mod: assert property (p_mod) else $error("modulo beside rev");
  property p_tbl; pacc_req.valid && pacc_req.table_op |=> pacc_rsp.valid &&
    pacc_rsp.paddr[15:0] == $past(pacc_req.ea); endproperty
  a_tbl: assert property (p_tbl) else $error("table addr wrong");
  property p_cfg; pacc_rsp.valid && !pacc_rsp.remap |->
    pacc_rsp.config_space == pacc_rsp.paddr[23]; endproperty
  a_cfg: assert property (p_cfg) else $error("space select wrong");
  property p_rmap; pacc_rsp.remap |-> !pacc_rsp.paddr[23] &&
    !pacc_rsp.paddr[0] && !pacc_rsp.write &&
    pacc_rsp.paddr[14:1] == $past(pacc_req.ea[14:1]); endproperty
  a_rmap: assert property (p_rmap) else $error("remap addr wrong");
  property p_ro; pacc_refused |-> !pacc_rsp.valid && $past(pacc_req.write);
  endproperty
  a_ro: assert property (p_ro) else $error("refusal wrong");
  property p_off; pacc_req.valid && !pacc_req.table_op && !pacc_req.ea[15]
    |=> !pacc_rsp.valid && !pacc_refused; endproperty
  a_off: assert property (p_off) else $error("low ea remapped");
endmodule
bind bpa_agu bpa_agu_props u_props (.mclk(mclk), .arst_n(arst_n),
  .xwr_req(xwr_req), .xwr_rsp(xwr_rsp), .xwr_modulo_allow(xwr_modulo_allow),
  .pacc_req(pacc_req), .pacc_rsp(pacc_rsp), .pacc_refused(pacc_refused));

// ---- test/bpa_core_model.sv ----
/* Pipeline pointer file beside bpa_agu; applies write-backs.
   Assumes answers come one cycle after each request. */
`timescale 1ns/100ps
module bpa_core_model
  import bpa_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // generator answer and pointer file
  input wire bpa_xwr_rsp_s xwr_rsp,
  output logic [15:0] w [16]
);
  // buffers start on 4 KB bounds, low bits zero
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 16; i++) w[i] <= 16'(i) << 12;
    end else if (xwr_rsp.valid && xwr_rsp.wb_en) begin
      w[xwr_rsp.wb_sel] <= xwr_rsp.wb_val;
    end
  end
  // no indirect read follows a control write here
endmodule

// ---- test/tb.sv ----
/* Bench for bpa_agu: registers, reversed writes, program addresses.
   Assumes bpa_core_model holds the pointer file. */
`timescale 1ns/100ps
module tb;
  import bpa_pkg::*;
  logic mclk, arst_n, reg_wr, reg_rd, xma, pref, ben, men, rve, wbe, rfs;
  logic [3:0] reg_addr, bsel;
  logic [14:0] piv;
  logic [15:0] reg_wdata, rdat, p, nw, e, ea, lea;
  logic [15:0] wf [16];
  logic [7:0] pg;
  logic [31:0] k;
  bpa_xwr_req_s xq;
  bpa_xwr_rsp_s xs;
  bpa_pacc_req_s pq;
  bpa_pacc_rsp_s ps;
  int n_fail, total_checks, i;
  bpa_agu dut (.mclk(mclk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rdat), .xwr_req(xq), .xwr_rsp(xs),
    .xwr_modulo_allow(xma), .pacc_req(pq), .pacc_rsp(ps),
    .pacc_refused(pref));
  bpa_core_model m (.mclk(mclk), .arst_n(arst_n), .xwr_rsp(xs), .w(wf));
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  function automatic logic [15:0] rv(logic [15:0] x);
    for (int j = 0; j < 16; j++) rv[j] = x[15-j];
  endfunction
  // carry runs downward: reverse, add, reverse back
  function automatic logic [15:0] radd(logic [15:0] a, logic [15:0] b);
    // lsb of a reversed result is always clear
    return rv(rv({a[15:1], 1'b0}) + rv(b)) & 16'hFFFE;
  endfunction
  task chk(input logic [23:0] g, input logic [23:0] x);
    total_checks++;
    if (g !== x) begin
      n_fail++;
      $display("ERROR %0t: got %h want %h", $time, g, x);
    end
  endtask
  task wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a, input logic [15:0] x);
    @(posedge mclk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 chk(rdat, x);
  endtask
  task cfg(input logic mo, input logic [3:0] s, input logic be,
    input logic [14:0] pv);
    men = mo;
    bsel = s;
    ben = be;
    piv = pv;
    wr(OFS_ADDR_MODE_CONTROL, {mo, 3'h0, s, 8'h00});
    wr(OFS_BITREV_CONTROL, {be, pv});
  endtask
  task xw(input bpa_amode_e md, input logic b, input logic [3:0] s,
    input logic [15:0] off);
    #1 p = wf[s];
    rve = s == bsel && s != PTR_SEL_NONE && ben && !b &&
      md inside {BPA_AM_PRE_INC, BPA_AM_POST_INC};
    wbe = md inside {[BPA_AM_POST_INC:BPA_AM_PRE_DEC]};
    nw = md inside {BPA_AM_POST_DEC, BPA_AM_PRE_DEC} ? p - off : p + off;
    if (rve) nw = radd(p, {piv, 1'b0});
    e = md inside {[BPA_AM_PRE_INC:BPA_AM_INDEXED]} ? nw : p;
    e[0] = e[0] & !rve;
    @(posedge mclk);
    xq <= '{1'b1, md, b, s, p, off};
    #1 chk(xma, men & !rve);
    @(posedge mclk);
    xq.valid <= 1'b0;
    #1 chk(xs.reversed, rve);
    chk(xs.valid, 1'b1);
    chk(xs.wb_sel, s);
    chk(xs.ea, e);
    chk(xs.wb_en, wbe);
    if (wbe) chk(xs.wb_val, nw);
    lea = xs.ea;
    @(posedge mclk);
  endtask
  task pa(input logic t, input logic w, input logic [15:0] a,
    input logic v, input logic rf, input logic [23:0] x);
    @(posedge mclk);
    pq <= '{1'b1, t, w, a};
    @(posedge mclk);
    pq.valid <= 1'b0;
    #1 chk(ps.valid, v);
    chk(pref, rf);
    chk(ps.config_space, v & t & x[23]);
    chk(ps.remap, v & !t);
    chk(ps.write, v & w);
    if (v) chk(ps.paddr, x);
  endtask
  task results;
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    {reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
    xq = '0;
    pq = '0;
    arst_n = 1'b0;
    n_fail = 0;
    total_checks = 0;
    k = $urandom(75);
    repeat (12) @(posedge mclk);
    arst_n <= 1'b1;
    rd(OFS_ADDR_MODE_CONTROL, RST_ADDR_MODE_CONTROL);
    rd(OFS_BITREV_CONTROL, RST_BITREV_CONTROL);
    rd(OFS_TABLE_PAGE, {8'h00, RST_TABLE_PAGE});
    rd(OFS_REMAP_PAGE_SELECT, {8'h00, RST_REMAP_PAGE_SELECT});
    rd(OFS_CORE_CONTROL, RST_CORE_CONTROL);
    rd(OFS_STATUS, {14'h0000, RST_STATUS});
    rd(4'h9, 16'h0000);
    $display("test reset values done");
    cfg(1'b1, 4'h2, 1'b1, 15'h0008);
    for (i = 0; i < 16; i++) begin
      xw(BPA_AM_POST_INC, 1'b0, 4'h2, 16'h0002);
      chk(lea, 16'h2000 | (rv(16'(i)) >> 11));
    end
    rd(OFS_STATUS, 16'h0001);
    for (i = 0; i < 14; i++) begin
      xw(bpa_amode_e'(3'(i % 7)), i > 6, 4'h2, 16'h0004);
    end
    $display("test reversed sequence done");
    for (i = 0; i < 40; i++) begin
      k = $urandom;
      cfg(k[0], k[1] ? 4'hF : 4'h2, k[2], k[17:3]);
      rd(OFS_BITREV_CONTROL, {ben, piv});
      xw(bpa_amode_e'(3'(k[20:18] % 7)), k[21], k[22] ? 4'h3 : 4'h2,
        {12'h000, k[25:23], 1'b0});
    end
    $display("test random writes done");
    wr(OFS_STATUS, 16'h0003);
    rd(OFS_STATUS, 16'h0000);
    rfs = 1'b0;
    for (i = 0; i < 24; i++) begin
      k = $urandom;
      pg = {i[0], k[6:0]};
      ea = k[31:16];
      rfs = rfs | (k[8] & k[9]);
      wr(OFS_TABLE_PAGE, {8'h00, pg});
      wr(OFS_REMAP_PAGE_SELECT, {8'h00, ~pg});
      wr(OFS_CORE_CONTROL, {13'h0000, k[8], 2'h0});
      rd(OFS_TABLE_PAGE, {8'h00, pg});
      pa(1'b1, k[9], ea, 1'b1, 1'b0, {pg, ea});
      pa(1'b0, k[9], {1'b1, ea[14:0]}, k[8] & !k[9], k[8] & k[9],
        {1'b0, ~pg, ea[14:1], 1'b0});
      pa(1'b0, 1'b0, {1'b0, ea[14:0]}, 1'b0, 1'b0, 24'h000000);
    end
    rd(OFS_STATUS, {14'h0000, rfs, 1'b0});
    $display("test program space done");
    results();
  end
  initial begin
    #200000;
    n_fail++;
    results();
  end
endmodule

// ---- verilog/bpa_agu.sv ----
/*
 * Bit-reversed X write address update and program-space address build.
 * Assumes the pipeline presents one X write and one program-space
 * request per cycle, and that it owns all modulo correction itself.
 */
// Local design decisions: the register addresses and the address-and-strobe port.
`timescale 1ns/100ps
module bpa_agu
  import bpa_pkg::*;
(
  // clock and reset
  input wire logic mclk,
  input wire logic arst_n,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // x write generator
  input wire bpa_xwr_req_s xwr_req,
  output bpa_xwr_rsp_s xwr_rsp,
  output logic xwr_modulo_allow,
  // program-space access
  input wire bpa_pacc_req_s pacc_req,
  output bpa_pacc_rsp_s pacc_rsp,
  output logic pacc_refused
);

  // ************************************************************
  // helpers
  // ************************************************************
  // reverse-carry add: carries run from msb toward lsb
  function automatic logic [15:0] rev_add(input logic [15:0] a,
                                          input logic [15:0] b);
    logic c;
    logic [15:0] s;
    c = 1'b0;
    s = 16'h0000;
    for (int i = 15; i >= 0; i--) begin
      s[i] = a[i] ^ b[i] ^ c;
      c = (a[i] & b[i]) | (c & (a[i] ^ b[i]));
    end
    return s;
  endfunction

  function automatic logic is_inc(input bpa_amode_e m);
    return (m == BPA_AM_PRE_INC) || (m == BPA_AM_POST_INC);
  endfunction

  // reversed addressing is word sized only, so bit 0 never counts
  function automatic logic [15:0] word_align(input logic [15:0] a);
    return {a[15:1], 1'b0};
  endfunction

  // ************************************************************
  // registers
  // ************************************************************
  logic [15:0] mode_ctl_reg, mode_ctl_next;
  logic [15:0] brev_reg, brev_next;
  logic [7:0] tpage_reg, tpage_next;
  logic [7:0] rpage_reg, rpage_next;
  logic [15:0] core_reg, core_next;
  logic [15:0] rdata_reg, rdata_next;
  logic [1:0] sticky_reg, sticky_next;
  bpa_xwr_rsp_s xwr_reg, xwr_next;
  bpa_pacc_rsp_s pacc_reg, pacc_next;
  logic refused_reg, refused_next;

  logic [3:0] ptr_sel_fld;
  logic rev_active;
  logic [15:0] pivot_bytes;
  logic [15:0] norm_ea;
  logic [15:0] norm_new;
  logic [15:0] rev_new;
  logic remap_hit;
  logic remap_write;

  assign ptr_sel_fld = mode_ctl_reg[POS_PTR_SEL_LO +: 4];
  // pivot is a word count; one left shift makes it a byte step
  assign pivot_bytes = {brev_reg[14:0], 1'b0};
  assign rev_active = (ptr_sel_fld != PTR_SEL_NONE)
                      && brev_reg[POS_REVERSE_ENABLE]
                      && is_inc(xwr_req.mode)
                      && !xwr_req.byte_op
                      && (xwr_req.ptr_sel == ptr_sel_fld);
  // modulo still allowed on X read side; only write side is gated
  assign xwr_modulo_allow = mode_ctl_reg[POS_XMOD_ENABLE]
                            && !rev_active;

  assign remap_hit = pacc_req.valid && !pacc_req.table_op
                     && pacc_req.ea[15]
                     && core_reg[POS_REMAP_WINDOW_ENABLE];
  assign remap_write = remap_hit && pacc_req.write;

  // ************************************************************
  // x write generator
  // ************************************************************
  always_comb begin
    norm_ea = xwr_req.ptr_val;
    norm_new = xwr_req.ptr_val;
    unique case (xwr_req.mode)
      BPA_AM_POST_INC: norm_new = xwr_req.ptr_val + xwr_req.offset;
      BPA_AM_POST_DEC: norm_new = xwr_req.ptr_val - xwr_req.offset;
      BPA_AM_PRE_INC: begin
        norm_new = xwr_req.ptr_val + xwr_req.offset;
        norm_ea = norm_new;
      end
      BPA_AM_PRE_DEC: begin
        norm_new = xwr_req.ptr_val - xwr_req.offset;
        norm_ea = norm_new;
      end
      BPA_AM_INDEXED: norm_ea = xwr_req.ptr_val + xwr_req.offset;
      BPA_AM_DIRECT, BPA_AM_INDIRECT: norm_ea = xwr_req.ptr_val;
      default: norm_ea = xwr_req.ptr_val;
    endcase
    // reversed carry on the pointer; lsb never takes part
    rev_new = rev_add(word_align(xwr_req.ptr_val), pivot_bytes);
    rev_new[0] = 1'b0;

    xwr_next = '0;
    xwr_next.valid = xwr_req.valid;
    xwr_next.wb_sel = xwr_req.ptr_sel;
    if (xwr_req.valid && rev_active) begin
      xwr_next.reversed = 1'b1;
      xwr_next.ea = (xwr_req.mode == BPA_AM_PRE_INC) ? rev_new
                    : word_align(xwr_req.ptr_val);
      xwr_next.wb_en = 1'b1;
      xwr_next.wb_val = rev_new;
    end else if (xwr_req.valid) begin
      xwr_next.ea = norm_ea;
      xwr_next.wb_en = xwr_req.mode inside {BPA_AM_POST_INC,
        BPA_AM_POST_DEC, BPA_AM_PRE_INC, BPA_AM_PRE_DEC};
      xwr_next.wb_val = norm_new;
    end
  end

  // ************************************************************
  // program-space address build
  // ************************************************************
  always_comb begin
    pacc_next = '0;
    refused_next = 1'b0;
    if (pacc_req.valid && pacc_req.table_op) begin
      // table path keeps ea bit 0 so unaligned access works
      pacc_next.valid = 1'b1;
      pacc_next.paddr = {tpage_reg, pacc_req.ea};
      pacc_next.config_space = tpage_reg[POS_CONFIG_SPACE];
      pacc_next.write = pacc_req.write;
    end else if (remap_write) begin
      refused_next = 1'b1;
    end else if (remap_hit) begin
      pacc_next.valid = 1'b1;
      pacc_next.remap = 1'b1;
      // bit 23 zero, page bit 0 lands on bit 15, lsb forced clear
      pacc_next.paddr = {1'b0, rpage_reg[7:1], rpage_reg[0],
                         pacc_req.ea[14:1], 1'b0};
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  always_comb begin
    mode_ctl_next = mode_ctl_reg;
    brev_next = brev_reg;
    tpage_next = tpage_reg;
    rpage_next = rpage_reg;
    core_next = core_reg;
    rdata_next = 16'h0000;
    // sticky: reversed write seen, remap write refused; set beats clear
    sticky_next = sticky_reg;
    if (reg_wr) begin
      unique case (reg_addr)
        OFS_ADDR_MODE_CONTROL: mode_ctl_next = reg_wdata;
        OFS_BITREV_CONTROL: brev_next = reg_wdata;
        OFS_TABLE_PAGE: tpage_next = reg_wdata[7:0];
        OFS_REMAP_PAGE_SELECT: rpage_next = reg_wdata[7:0];
        OFS_CORE_CONTROL: core_next = reg_wdata;
        OFS_STATUS: sticky_next = sticky_reg & ~reg_wdata[1:0];
        default: ;
      endcase
    end
    if (xwr_next.reversed) begin
      sticky_next[0] = 1'b1;
    end
    if (refused_next) begin
      sticky_next[1] = 1'b1;
    end
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_ADDR_MODE_CONTROL: rdata_next = mode_ctl_reg;
        OFS_BITREV_CONTROL: rdata_next = brev_reg;
        OFS_TABLE_PAGE: rdata_next = {8'h00, tpage_reg};
        OFS_REMAP_PAGE_SELECT: rdata_next = {8'h00, rpage_reg};
        OFS_CORE_CONTROL: rdata_next = core_reg;
        OFS_STATUS: rdata_next = {14'h0000, sticky_reg};
        default: rdata_next = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_ctl_reg <= RST_ADDR_MODE_CONTROL;
      brev_reg <= RST_BITREV_CONTROL;
      tpage_reg <= RST_TABLE_PAGE;
      rpage_reg <= RST_REMAP_PAGE_SELECT;
      core_reg <= RST_CORE_CONTROL;
      rdata_reg <= RST_READ_DATA;
      sticky_reg <= RST_STATUS;
    end else begin
      mode_ctl_reg <= mode_ctl_next;
      brev_reg <= brev_next;
      tpage_reg <= tpage_next;
      rpage_reg <= rpage_next;
      core_reg <= core_next;
      rdata_reg <= rdata_next;
      sticky_reg <= sticky_next;
    end
  end

  // x write answer, one cycle after the request
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      xwr_reg <= '0;
    end else begin
      xwr_reg <= xwr_next;
    end
  end

  // program-space answer and refusal pulse
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pacc_reg <= '0;
      refused_reg <= 1'b0;
    end else begin
      pacc_reg <= pacc_next;
      refused_reg <= refused_next;
    end
  end

  assign reg_rdata = rdata_reg;
  assign xwr_rsp = xwr_reg;
  assign pacc_rsp = pacc_reg;
  assign pacc_refused = refused_reg;

endmodule

// ---- verilog/bpa_pkg.sv ----
/*
 * Shared constants and carriers for the bit-reverse and program-space
 * address generator. Assumes a 16-bit core with a plain register port.
 */
package bpa_pkg;

  // ************************************************************
  // register map (word offsets on the plain register port)
  // ************************************************************
  localparam logic [3:0] OFS_ADDR_MODE_CONTROL = 4'h0;
  localparam logic [3:0] OFS_BITREV_CONTROL = 4'h1;
  localparam logic [3:0] OFS_TABLE_PAGE = 4'h2;
  localparam logic [3:0] OFS_REMAP_PAGE_SELECT = 4'h3;
  localparam logic [3:0] OFS_CORE_CONTROL = 4'h4;
  localparam logic [3:0] OFS_STATUS = 4'h5;

  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int POS_REVERSE_ENABLE = 15;
  localparam int POS_XMOD_ENABLE = 15;
  localparam int POS_REMAP_WINDOW_ENABLE = 2;
  localparam int POS_CONFIG_SPACE = 7;
  localparam int POS_PTR_SEL_LO = 8;
  localparam logic [3:0] PTR_SEL_NONE = 4'hF;
  localparam logic [15:0] RST_ADDR_MODE_CONTROL = 16'h0F00;
  localparam logic [15:0] RST_BITREV_CONTROL = 16'h0000;
  localparam logic [7:0] RST_TABLE_PAGE = 8'h00;
  localparam logic [7:0] RST_REMAP_PAGE_SELECT = 8'h00;
  localparam logic [15:0] RST_CORE_CONTROL = 16'h0000;
  localparam logic [1:0] RST_STATUS = 2'h0;
  localparam logic [15:0] RST_READ_DATA = 16'h0000;

  // ************************************************************
  // addressing modes of an X write request
  // ************************************************************
  typedef enum logic [2:0] {
    BPA_AM_DIRECT = 3'h0,
    BPA_AM_INDIRECT = 3'h1,
    BPA_AM_POST_INC = 3'h2,
    BPA_AM_POST_DEC = 3'h3,
    BPA_AM_PRE_INC = 3'h4,
    BPA_AM_PRE_DEC = 3'h5,
    BPA_AM_INDEXED = 3'h6
  } bpa_amode_e;

  typedef struct packed {
    logic valid;
    bpa_amode_e mode;
    logic byte_op;
    logic [3:0] ptr_sel;
    logic [15:0] ptr_val;
    logic [15:0] offset;
  } bpa_xwr_req_s;

  typedef struct packed {
    logic valid;
    logic [15:0] ea;
    logic wb_en;
    logic [3:0] wb_sel;
    logic [15:0] wb_val;
    logic reversed;
  } bpa_xwr_rsp_s;

  typedef struct packed {
    logic valid;
    logic table_op;
    logic write;
    logic [15:0] ea;
  } bpa_pacc_req_s;

  typedef struct packed {
    logic valid;
    logic [23:0] paddr;
    logic config_space;
    logic write;
    logic remap;
  } bpa_pacc_rsp_s;

endpackage
